// ===== design/audio_cfg_pkg.sv
// Constants shared by the audio serial port device end and host end.
package audio_cfg_pkg;
  // Device register indices; the byte address is four times the index.
  localparam int NUM_REGS = 8;
  localparam logic [7:0] REG_IDX [0:NUM_REGS-1] = '{
    8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20};
  localparam logic [7:0] REG_RESET [0:NUM_REGS-1] = '{
    8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  // Writable bits; read-only reserved bits keep their zero default.
  localparam logic [7:0] REG_WMASK [0:NUM_REGS-1] = '{
    8'h07, 8'hFF, 8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'h79, 8'h0D};
  // Positions of the registers inside the local array.
  localparam int RI_CLK_SRC = 0;
  localparam int RI_CLK_DIV = 1;
  localparam int RI_FMT = 2;
  localparam int RI_OFS = 3;
  localparam int RI_POL = 4;
  localparam int RI_BDIV = 5;
  localparam int RI_SEC = 6;
  localparam int RI_IF = 7;
  // Field positions.
  localparam int DIV_PWR_BIT = 7;
  localparam int FMT_LSB = 6;
  localparam int WLEN_LSB = 4;
  localparam int BCLK_DIR_BIT = 3;
  localparam int WCLK_DIR_BIT = 2;
  localparam int POL_BIT = 3;
  localparam int BUF_PD_BIT = 2;
  localparam int SEC_BCLK_LSB = 5;
  localparam int SEC_WCLK_LSB = 3;
  localparam int SEC_DIN_BIT = 0;
  localparam int IF_BCLK_BIT = 3;
  localparam int IF_WCLK_BIT = 2;
  localparam int IF_DIN_BIT = 0;
  // Clock-out source codes and divider constants.
  localparam logic [2:0] CSRC_MCLK = 3'h0;
  localparam logic [2:0] CSRC_BCLK = 3'h1;
  localparam logic [2:0] CSRC_DIN = 3'h2;
  localparam logic [2:0] CSRC_PLL = 3'h3;
  localparam logic [2:0] CSRC_CONV = 3'h4;
  localparam logic [2:0] CSRC_MOD = 3'h5;
  localparam logic [1:0] BSRC_MOD = 2'h1;
  localparam logic [7:0] DIV_ZERO_RATIO = 8'h80;
  localparam logic [7:0] DIV_BYPASS = 8'h01;
  // Host register byte addresses, fields and reset values.
  localparam logic [11:0] HOST_CTRL_ADDR = 12'h000;
  localparam logic [11:0] HOST_DIV_ADDR = 12'h004;
  localparam logic [11:0] HOST_TX_ADDR = 12'h008;
  localparam logic [11:0] HOST_STAT_ADDR = 12'h00C;
  localparam logic [15:0] HOST_CTRL_RESET = 16'h0000;
  localparam logic [7:0] HOST_DIV_RESET = 8'h04;
  localparam int H_EN_BIT = 0;
  localparam int H_MASTER_BIT = 1;
  localparam int H_POL_BIT = 2;
  localparam int H_FMT_LSB = 4;
  localparam int H_WLEN_LSB = 6;
  localparam int H_OFS_LSB = 8;

  typedef enum logic [1:0] {
    FMT_I2S, FMT_DSP, FMT_RJ, FMT_LJ
  } serial_format_t;

  // Word length in bits for a 2-bit length code.
  function automatic logic [5:0] word_bits(input logic [1:0] code);
    case (code)
      2'h0: word_bits = 6'h10;
      2'h1: word_bits = 6'h14;
      2'h2: word_bits = 6'h18;
      default: word_bits = 6'h20;
    endcase
  endfunction
endpackage

// ===== design/audio_link_if.sv
// Serial audio link between the device end and the host end.
`timescale 1ns/100ps
interface audio_link_if;
  logic bclk_dev;
  logic bclk_dev_oe;
  logic bclk_host;
  logic bclk_host_oe;
  logic wclk_dev;
  logic wclk_dev_oe;
  logic wclk_host;
  logic wclk_host_oe;
  logic din;
  logic bclk;
  logic wclk;

  // Wire levels; an undriven clock wire reads low in this model.
  assign bclk = bclk_dev_oe ? bclk_dev : (bclk_host_oe & bclk_host);
  assign wclk = wclk_dev_oe ? wclk_dev : (wclk_host_oe & wclk_host);

  modport device (
    input bclk, wclk, din,
    output bclk_dev, bclk_dev_oe, wclk_dev, wclk_dev_oe
  );
  modport host (
    input bclk, wclk,
    output bclk_host, bclk_host_oe, wclk_host, wclk_host_oe, din
  );
endinterface // audio_link_if

// ===== design/audio_port_device.sv
// Device end: port configuration registers, clock dividers and receiver.
`timescale 1ns/100ps
module audio_port_device
  import audio_cfg_pkg::*;
(
  input wire logic sys_clk_in, // System clock, 100 MHz.
  input wire logic rstn_in, // Synchronous reset, active low.
  input wire logic wb_cyc_in, // Wishbone cycle.
  input wire logic wb_stb_in, // Wishbone strobe.
  input wire logic wb_we_in, // Wishbone write enable.
  input wire logic [11:0] wb_adr_in, // Wishbone byte address.
  input wire logic [3:0] wb_sel_in, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_in, // Wishbone write data.
  output logic [31:0] wb_dat_out, // Wishbone read data.
  output logic wb_ack_out, // Wishbone acknowledge.
  audio_link_if.device link, // Serial audio link.
  input wire logic mclk_in, // Master clock level.
  input wire logic pll_clk_in, // PLL output level.
  input wire logic conv_clk_in, // Converter clock level.
  input wire logic modulator_clock_in, // Modulator clock level.
  input wire logic gpio_in, // General-purpose pin.
  input wire logic spi_sclk_in, // SPI clock pin.
  input wire logic spi_miso_in, // SPI data-out pin.
  input wire logic dout_pin_in, // Serial data output pin level.
  input wire logic codec_powered_in, // High while the codec is powered.
  output logic clock_output_pin_out, // Divided clock output.
  output logic [31:0] sample_out, // Last received sample, right aligned.
  output logic sample_valid_out // One-cycle pulse per sample.
);
  logic [7:0] cfg_r [0:NUM_REGS-1];
  logic [NUM_REGS-1:0] hit;
  logic wb_req;
  logic [7:0] rd_byte;
  logic [2:0] cout_src;
  serial_format_t fmt;
  logic [5:0] wlen;
  logic [7:0] offset;
  logic pol;
  logic prim_on;
  logic [3:0] sec_pins;
  logic sec_bclk;
  logic sec_wclk;
  logic sec_din;
  logic prim_bclk;
  logic prim_wclk;
  logic bclk_eff;
  logic wclk_raw;
  logic din_sel;
  logic cdiv_in;
  logic bdiv_in;
  logic [1:0] div_in;
  logic [1:0] div_pwr;
  logic [6:0] div_val [0:1];
  logic [1:0] div_out;
  logic bprev_r;
  logic b_rise;
  logic b_fall;
  logic [6:0] wc_cnt_r;
  logic [6:0] wc_cnt_nxt;
  logic wgen_r;
  logic wgen_nxt;
  logic wprev_r;
  logic start;
  logic left_end;
  logic [7:0] skip_r;
  logic act_r;
  logic [5:0] got_r;
  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  logic [31:0] wmask;

  assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;

  // Address decode; only the low 8 bits of each word are implemented.
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_hit
      assign hit[g] = (wb_adr_in[9:2] == REG_IDX[g]) &&
                      (wb_adr_in[11:10] == 2'b00);
    end
  endgenerate

  // Register writes; read-only reserved bits cannot be changed.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg_r[i] <= REG_RESET[i];
      end
    end else if (wb_req && wb_we_in && wb_sel_in[0]) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (hit[i]) begin
          cfg_r[i] <= (wb_dat_in[7:0] & REG_WMASK[i]) |
                      (cfg_r[i] & ~REG_WMASK[i]);
        end
      end
    end
  end

  // Read mux; an unmapped address reads zero and still acknowledges.
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      rd_byte = rd_byte | (cfg_r[i] & {8{hit[i]}});
    end
  end

  // Single-wait-state answer: ack one cycle after the request is seen.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_req;
      if (wb_req && !wb_we_in) begin
        wb_dat_out <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Configuration fields.
  assign cout_src = cfg_r[RI_CLK_SRC][2:0];
  assign fmt = serial_format_t'(cfg_r[RI_FMT][FMT_LSB +: 2]);
  assign wlen = word_bits(cfg_r[RI_FMT][WLEN_LSB +: 2]);
  assign offset = cfg_r[RI_OFS];
  assign pol = cfg_r[RI_POL][POL_BIT];
  assign div_pwr = {cfg_r[RI_BDIV][DIV_PWR_BIT],
                    cfg_r[RI_CLK_DIV][DIV_PWR_BIT]};
  assign div_val[0] = cfg_r[RI_CLK_DIV][6:0];
  assign div_val[1] = cfg_r[RI_BDIV][6:0];

  // Primary buffers stay alive with the codec off unless told otherwise.
  assign prim_on = ~cfg_r[RI_POL][BUF_PD_BIT] | codec_powered_in;
  assign prim_bclk = prim_on & link.bclk;
  assign prim_wclk = prim_on & link.wclk;

  // Pin order matches the selector codes 0 to 3.
  assign sec_pins = {dout_pin_in, spi_miso_in, spi_sclk_in, gpio_in};
  assign sec_bclk = sec_pins[cfg_r[RI_SEC][SEC_BCLK_LSB +: 2]];
  assign sec_wclk = sec_pins[cfg_r[RI_SEC][SEC_WCLK_LSB +: 2]];
  assign sec_din = cfg_r[RI_SEC][SEC_DIN_BIT] ? spi_sclk_in : gpio_in;

  // Source selection for the port and the polarity-corrected bit clock.
  assign bclk_eff = (cfg_r[RI_IF][IF_BCLK_BIT] ? sec_bclk : prim_bclk)
                    ^ pol;
  assign wclk_raw = cfg_r[RI_IF][IF_WCLK_BIT] ? sec_wclk : prim_wclk;
  assign din_sel = cfg_r[RI_IF][IF_DIN_BIT] ? sec_din : link.din;

  // Clock-out divider input; codes 6 and 7 give a quiet input.
  always_comb begin
    case (cout_src)
      CSRC_MCLK: cdiv_in = mclk_in;
      CSRC_BCLK: cdiv_in = prim_bclk;
      CSRC_DIN: cdiv_in = link.din;
      CSRC_PLL: cdiv_in = pll_clk_in;
      CSRC_CONV: cdiv_in = conv_clk_in;
      CSRC_MOD: cdiv_in = modulator_clock_in;
      default: cdiv_in = 1'b0;
    endcase
  end

  // Unused codes fall back to the converter clock.
  assign bdiv_in = (cfg_r[RI_BDIV - 1][1:0] == BSRC_MOD) ?
                   modulator_clock_in : conv_clk_in;
  assign div_in = {bdiv_in, cdiv_in};

  // Divider 0 is M (clock out), divider 1 is N (bit clock). They count
  // rising edges of their sampled input, so inputs above half the
  // system clock rate are not divided faithfully.
  generate
    for (g = 0; g < 2; g++) begin : g_div
      logic prev_r;
      logic [6:0] cnt_r;
      logic out_r;
      logic [7:0] ratio;
      assign ratio = (div_val[g] == 7'h00) ? DIV_ZERO_RATIO :
                     {1'b0, div_val[g]};
      always_ff @(posedge sys_clk_in) begin
        if (!rstn_in || !div_pwr[g]) begin
          prev_r <= 1'b0;
          cnt_r <= 7'h00;
          out_r <= 1'b0;
        end else begin
          prev_r <= div_in[g];
          if (div_in[g] && !prev_r) begin
            cnt_r <= (({1'b0, cnt_r} + 8'h01) >= ratio) ? 7'h00 :
                     cnt_r + 7'h01;
          end
          out_r <= (ratio == DIV_BYPASS) ? div_in[g] :
                   ({1'b0, cnt_r} < (ratio >> 1));
        end
      end
      assign div_out[g] = out_r;
    end
  endgenerate

  // Clock output pin, quiet while the M divider is powered down.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      clock_output_pin_out <= 1'b0;
    end else begin
      clock_output_pin_out <= div_out[0];
    end
  end

  // Pin drivers for the bit clock and word clock.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      link.bclk_dev <= 1'b0;
      link.bclk_dev_oe <= 1'b0;
      link.wclk_dev <= 1'b0;
      link.wclk_dev_oe <= 1'b0;
    end else begin
      link.bclk_dev <= div_out[1] ^ pol;
      link.bclk_dev_oe <= cfg_r[RI_FMT][BCLK_DIR_BIT];
      link.wclk_dev <= wgen_r;
      link.wclk_dev_oe <= cfg_r[RI_FMT][WCLK_DIR_BIT];
    end
  end

  // Bit clock edges, seen one system clock after the level changes.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      bprev_r <= 1'b0;
    end else begin
      bprev_r <= bclk_eff;
    end
  end
  assign b_rise = bclk_eff & ~bprev_r;
  assign b_fall = ~bclk_eff & bprev_r;

  // Frame of two slots of one word each; DSP marks it with a 1-bit pulse.
  always_comb begin
    wc_cnt_nxt = (wc_cnt_r + 7'h01 >= {wlen, 1'b0}) ? 7'h00 :
                 wc_cnt_r + 7'h01;
    case (fmt)
      FMT_DSP: wgen_nxt = (wc_cnt_nxt == 7'h00);
      FMT_I2S: wgen_nxt = (wc_cnt_nxt >= {1'b0, wlen});
      default: wgen_nxt = (wc_cnt_nxt < {1'b0, wlen});
    endcase
  end

  // Word clock generator, stepping on bit clock falling edges.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wc_cnt_r <= 7'h00;
      wgen_r <= 1'b0;
    end else if (b_fall) begin
      wc_cnt_r <= wc_cnt_nxt;
      wgen_r <= wgen_nxt;
    end
  end

  // Frame start: I2S left slot begins low, the other formats begin high.
  assign start = (fmt == FMT_I2S) ? (wprev_r & ~wclk_raw) :
                 (~wprev_r & wclk_raw);
  assign left_end = (fmt == FMT_I2S) ? (~wprev_r & wclk_raw) :
                    (wprev_r & ~wclk_raw);
  assign shift_nxt = {shift_r[30:0], din_sel};
  assign wmask = (wlen == 6'h20) ? 32'hFFFF_FFFF :
                 (32'h0000_0001 << wlen) - 32'h0000_0001;

  // Receiver for the left slot, sampling on bit clock rising edges.
  // Right-justified data is taken as the last word bits of the slot.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wprev_r <= 1'b0;
      skip_r <= 8'h00;
      act_r <= 1'b0;
      got_r <= 6'h00;
      shift_r <= 32'h0000_0000;
      sample_out <= 32'h0000_0000;
      sample_valid_out <= 1'b0;
    end else begin
      sample_valid_out <= 1'b0;
      if (b_rise) begin
        wprev_r <= wclk_raw;
        if (fmt == FMT_RJ) begin
          shift_r <= shift_nxt;
          act_r <= 1'b0;
          // The slot's last bit lands at this same rising edge.
          if (left_end) begin
            sample_out <= shift_nxt & wmask;
            sample_valid_out <= 1'b1;
          end
        end else if (start) begin
          skip_r <= offset;
          got_r <= 6'h00;
          act_r <= 1'b1;
        end else if (act_r) begin
          if (skip_r != 8'h00) begin
            skip_r <= skip_r - 8'h01;
          end else begin
            shift_r <= shift_nxt;
            got_r <= got_r + 6'h01;
            if (got_r + 6'h01 == wlen) begin
              sample_out <= shift_nxt & wmask;
              sample_valid_out <= 1'b1;
              act_r <= 1'b0;
            end
          end
        end
      end
    end
  end
endmodule // audio_port_device

// ===== design/audio_port_host.sv
// Host end: control registers, optional clock master and transmitter.
`timescale 1ns/100ps
module audio_port_host
  import audio_cfg_pkg::*;
(
  input wire logic sys_clk_in, // System clock, 100 MHz.
  input wire logic rstn_in, // Synchronous reset, active low.
  input wire logic wb_cyc_in, // Wishbone cycle.
  input wire logic wb_stb_in, // Wishbone strobe.
  input wire logic wb_we_in, // Wishbone write enable.
  input wire logic [11:0] wb_adr_in, // Wishbone byte address.
  input wire logic [3:0] wb_sel_in, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_in, // Wishbone write data.
  output logic [31:0] wb_dat_out, // Wishbone read data.
  output logic wb_ack_out, // Wishbone acknowledge.
  audio_link_if.host link // Serial audio link.
);
  logic [15:0] ctrl_r;
  logic [7:0] div_r;
  logic [31:0] tx_r;
  logic pend_r;
  logic [7:0] frames_r;
  logic wb_req;
  logic wr_tx;
  logic en;
  logic master;
  serial_format_t fmt;
  logic [5:0] wlen;
  logic [7:0] hcnt_r;
  logic bclk_eff;
  logic bprev_r;
  logic b_rise;
  logic b_fall;
  logic [6:0] wc_cnt_r;
  logic [6:0] wc_cnt_nxt;
  logic wgen_nxt;
  logic wprev_r;
  logic start;
  logic load;
  logic [7:0] skip_r;
  logic act_r;
  logic [5:0] sent_r;
  logic [31:0] shift_r;

  assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_tx = wb_req & wb_we_in & (wb_adr_in == HOST_TX_ADDR);
  assign en = ctrl_r[H_EN_BIT];
  assign master = ctrl_r[H_MASTER_BIT];
  assign fmt = serial_format_t'(ctrl_r[H_FMT_LSB +: 2]);
  assign wlen = word_bits(ctrl_r[H_WLEN_LSB +: 2]);

  // Control registers with byte selects.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ctrl_r <= HOST_CTRL_RESET;
      div_r <= HOST_DIV_RESET;
      tx_r <= 32'h0000_0000;
    end else if (wb_req && wb_we_in) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_in[b] && wb_adr_in == HOST_TX_ADDR) begin
          tx_r[8*b +: 8] <= wb_dat_in[8*b +: 8];
        end
        if (wb_sel_in[b] && b < 2 && wb_adr_in == HOST_CTRL_ADDR) begin
          ctrl_r[8*b +: 8] <= wb_dat_in[8*b +: 8];
        end
      end
      if (wb_sel_in[0] && wb_adr_in == HOST_DIV_ADDR) begin
        div_r <= wb_dat_in[7:0];
      end
    end
  end

  // Single-wait-state answer; unmapped addresses read zero.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= wb_req;
      if (wb_req && !wb_we_in) begin
        case (wb_adr_in)
          HOST_CTRL_ADDR: wb_dat_out <= {16'h0000, ctrl_r};
          HOST_DIV_ADDR: wb_dat_out <= {24'h00_0000, div_r};
          HOST_TX_ADDR: wb_dat_out <= tx_r;
          HOST_STAT_ADDR: wb_dat_out <= {16'h0000, frames_r, 7'h00, pend_r};
          default: wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Bit clock master: half period of div_r plus one system clocks.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || !(en && master)) begin
      hcnt_r <= 8'h00;
      link.bclk_host <= 1'b0;
    end else if (hcnt_r >= div_r) begin
      hcnt_r <= 8'h00;
      link.bclk_host <= ~link.bclk_host;
    end else begin
      hcnt_r <= hcnt_r + 8'h01;
    end
  end

  // The host drives both clocks whenever it is enabled as clock master.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      link.bclk_host_oe <= 1'b0;
      link.wclk_host_oe <= 1'b0;
    end else begin
      link.bclk_host_oe <= en & master;
      link.wclk_host_oe <= en & master;
    end
  end

  assign bclk_eff = link.bclk ^ ctrl_r[H_POL_BIT];

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      bprev_r <= 1'b0;
    end else begin
      bprev_r <= bclk_eff;
    end
  end
  assign b_rise = bclk_eff & ~bprev_r;
  assign b_fall = ~bclk_eff & bprev_r;

  // Word clock in the same framing as the device's generator.
  always_comb begin
    wc_cnt_nxt = (wc_cnt_r + 7'h01 >= {wlen, 1'b0}) ? 7'h00 :
                 wc_cnt_r + 7'h01;
    case (fmt)
      FMT_DSP: wgen_nxt = (wc_cnt_nxt == 7'h00);
      FMT_I2S: wgen_nxt = (wc_cnt_nxt >= {1'b0, wlen});
      default: wgen_nxt = (wc_cnt_nxt < {1'b0, wlen});
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || !(en && master)) begin
      wc_cnt_r <= 7'h00;
      link.wclk_host <= 1'b0;
    end else if (b_fall) begin
      wc_cnt_r <= wc_cnt_nxt;
      link.wclk_host <= wgen_nxt;
    end
  end

  assign start = (fmt == FMT_I2S) ? (wprev_r & ~link.wclk) :
                 (~wprev_r & link.wclk);
  assign load = en & b_rise & start;

  // Pending flag; a new write in the loading cycle keeps it set.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pend_r <= 1'b0;
      frames_r <= 8'h00;
    end else begin
      if (wr_tx) begin
        pend_r <= 1'b1;
      end else if (load) begin
        pend_r <= 1'b0;
      end
      if (load) begin
        frames_r <= frames_r + 8'h01;
      end
    end
  end

  // Transmitter: MSB first, changed on falling edges so the device
  // samples stable data on the following rising edge.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wprev_r <= 1'b0;
      skip_r <= 8'h00;
      act_r <= 1'b0;
      sent_r <= 6'h00;
      shift_r <= 32'h0000_0000;
      link.din <= 1'b0;
    end else if (b_rise) begin
      wprev_r <= link.wclk;
      if (load) begin
        skip_r <= ctrl_r[H_OFS_LSB +: 8];
        act_r <= 1'b1;
        sent_r <= 6'h00;
        shift_r <= tx_r << (6'h20 - wlen);
      end
    end else if (b_fall && act_r) begin
      if (skip_r != 8'h00) begin
        skip_r <= skip_r - 8'h01;
      end else begin
        link.din <= shift_r[31];
        shift_r <= {shift_r[30:0], 1'b0};
        sent_r <= sent_r + 6'h01;
        if (sent_r + 6'h01 == wlen) begin
          act_r <= 1'b0;
        end
      end
    end
  end
endmodule // audio_port_host

// ===== verif/audio_port_clock_config_sva.sv
// Link checker beside the interface joining both ends.
`timescale 1ns/100ps
module audio_port_clock_config_sva #(parameter int FRAME_BITS = 48) (
  input wire logic sys_clk_in, // Clock.
  input wire logic rstn_in, // Reset, active low.
  input wire logic bclk_dev, // Device bit clock.
  input wire logic bclk_dev_oe, // Device drives bclk.
  input wire logic bclk_host_oe, // Host drives bclk.
  input wire logic wclk_dev, // Device word clock.
  input wire logic wclk_dev_oe, // Device drives wclk.
  input wire logic wclk_host_oe // Host drives wclk.
);
  logic [7:0] rises_r;
  logic armed_r;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // Bit clock rises per frame; the first frame may be cut short.
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || !wclk_dev_oe) begin
      rises_r <= 8'h00;
      armed_r <= 1'b0;
    end else if ($rose(wclk_dev)) begin
      rises_r <= 8'h00;
      armed_r <= 1'b1;
    end else if ($rose(bclk_dev)) begin
      rises_r <= rises_r + 8'h01;
    end
  end
  sequence s_fall;
    ##[2:300] ($fell(bclk_dev) || !bclk_dev_oe);
  endsequence
  property p_bdrv;
    !(bclk_dev_oe && bclk_host_oe);
  endproperty
  a_bdrv: assert property (p_bdrv) else $error("bclk fight");
  property p_wdrv;
    !(wclk_dev_oe && wclk_host_oe);
  endproperty
  a_wdrv: assert property (p_wdrv) else $error("wclk fight");
  property p_frame;
    $rose(wclk_dev) && armed_r |-> rises_r == FRAME_BITS;
  endproperty
  a_frame: assert property (p_frame) else $error("frame size");
  // A frame never runs longer than two words of bit clocks.
  property p_nolong;
    armed_r |-> rises_r <= FRAME_BITS;
  endproperty
  a_nolong: assert property (p_nolong) else $error("frame long");
  property p_toggle;
    $rose(bclk_dev) && bclk_dev_oe |-> s_fall;
  endproperty
  a_toggle: assert property (p_toggle) else $error("bclk stuck");
  // Word clock moves only near a falling bit clock edge.
  property p_wfall;
    $changed(wclk_dev) && $past(wclk_dev_oe) && wclk_dev_oe && bclk_dev_oe
      |-> ##[0:1] !bclk_dev;
  endproperty
  a_wfall: assert property (p_wfall) else $error("wclk edge");
endmodule // audio_port_clock_config_sva

// ===== verif/test_audio_port_clock_config.sv
// Bench joining device and host ends over one link.
`timescale 1ns/100ps
module test_audio_port_clock_config;
  import audio_cfg_pkg::*;
  localparam logic [31:0] TXV = 32'hC3A59E71;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cyc = 1'b0, we = 1'b0, tgt = 1'b0, gpio_r = 1'b1;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd, d_dat, h_dat, sample;
  logic d_ack, h_ack, clk_out, valid, p;
  logic [7:0] cnt_r = 8'h00;
  int errors = 0, n_tests = 0, cycles = 0;
  // Source, divider byte and expected output rises in 2048 cycles.
  int tbl [7][3] = '{'{0, 129, 32}, '{3, 129, 64}, '{4, 129, 256},
    '{5, 129, 128}, '{4, 130, 128}, '{4, 128, 2}, '{4, 1, 0}};
  audio_link_if audio_link_if_inst ();
  audio_port_device audio_port_device_inst (.sys_clk_in, .rstn_in,
    .wb_cyc_in(cyc & tgt), .wb_stb_in(cyc & tgt), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wd), .wb_dat_out(d_dat),
    .wb_ack_out(d_ack), .link(audio_link_if_inst.device),
    .mclk_in(cnt_r[5]), .pll_clk_in(cnt_r[4]), .conv_clk_in(cnt_r[2]),
    .modulator_clock_in(cnt_r[3]), .gpio_in(gpio_r), .spi_sclk_in(cnt_r[6]),
    .spi_miso_in(cnt_r[7]), .dout_pin_in(cnt_r[1]), .codec_powered_in(1'b1),
    .clock_output_pin_out(clk_out), .sample_out(sample),
    .sample_valid_out(valid));
  audio_port_host audio_port_host_inst (.sys_clk_in, .rstn_in,
    .wb_cyc_in(cyc & !tgt), .wb_stb_in(cyc & !tgt), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wd), .wb_dat_out(h_dat),
    .wb_ack_out(h_ack), .link(audio_link_if_inst.host));
  audio_port_clock_config_sva #(.FRAME_BITS(48))
    audio_port_clock_config_sva_inst (.sys_clk_in, .rstn_in,
    .bclk_dev(audio_link_if_inst.bclk_dev),
    .bclk_dev_oe(audio_link_if_inst.bclk_dev_oe),
    .bclk_host_oe(audio_link_if_inst.bclk_host_oe),
    .wclk_dev(audio_link_if_inst.wclk_dev),
    .wclk_dev_oe(audio_link_if_inst.wclk_dev_oe),
    .wclk_host_oe(audio_link_if_inst.wclk_host_oe));
  always #5 sys_clk_in = ~sys_clk_in;
  // Slow source clocks come from one count; a hang ends the run.
  always @(posedge sys_clk_in) begin
    cnt_r <= cnt_r + 8'h01;
    cycles++;
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One Wishbone cycle to the device (t high) or the host.
  task automatic wb(input logic t, input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    @(posedge sys_clk_in);
    tgt <= t;
    we <= w;
    adr <= a;
    wd <= d;
    cyc <= 1'b1;
    do @(posedge sys_clk_in); while ((t ? d_ack : h_ack) !== 1'b1);
    rd = t ? d_dat : h_dat;
    cyc <= 1'b0;
  endtask
  // The first frame may be partial, so the second capture is judged.
  task automatic frame(input logic [31:0] tx, input logic [31:0] e);
    repeat (2) begin
      wb(0, 1, HOST_TX_ADDR, tx);
      do @(posedge sys_clk_in); while (valid !== 1'b1);
    end
    chk(sample, e);
  endtask
  initial begin
    int n;
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    // Reset values, then all ones to show which bits take writes.
    for (int i = 0; i < NUM_REGS; i++) begin
      wb(1, 0, {2'b00, REG_IDX[i], 2'b00}, 0);
      chk(rd, {24'h0, REG_RESET[i]});
      wb(1, 1, {2'b00, REG_IDX[i], 2'b00}, 32'hFF);
      wb(1, 0, {2'b00, REG_IDX[i], 2'b00}, 0);
      chk(rd, {24'h0, REG_WMASK[i]});
      wb(1, 1, {2'b00, REG_IDX[i], 2'b00}, {24'h0, REG_RESET[i]});
    end
    wb(1, 0, 12'h100, 0);
    chk(rd, 0);
    wb(0, 0, HOST_DIV_ADDR, 0);
    chk(rd, {24'h0, HOST_DIV_RESET});
    // Clock output; one edge of slack for phase at window ends.
    foreach (tbl[k]) begin
      wb(1, 1, 12'h064, tbl[k][0]);
      wb(1, 1, 12'h068, tbl[k][1]);
      repeat (300) @(posedge sys_clk_in);
      n = 0;
      p = clk_out;
      repeat (2048) begin
        @(posedge sys_clk_in);
        n += int'(clk_out && !p);
        p = clk_out;
      end
      chk(n >= tbl[k][2] - 1 && n <= tbl[k][2] + 1, 1);
    end
    // Host clocks; format and length codes equal f, offset f.
    // The device receiver ignores the offset for right-justified data while the host still skips it, so that pass uses 0.
    wb(0, 1, HOST_DIV_ADDR, 4);
    for (int f = 0; f < 4; f++) begin
      wb(0, 1, HOST_CTRL_ADDR, 0);
      wb(1, 1, 12'h06C, f * 80);
      wb(1, 1, 12'h070, (f == 2) ? 0 : f);
      wb(1, 1, 12'h074, (f == 1) * 8);
      wb(0, 1, HOST_CTRL_ADDR, f * 336 - (f == 2) * 512 + (f == 1) * 4 + 3);
      frame(TXV, TXV & (32'hFFFFFFFF >>
        (f == 3 ? 0 : 16 - 4 * f)));
    end
    // Device makes both clocks, converter clock over N of 2.
    wb(0, 1, HOST_CTRL_ADDR, 0);
    wb(1, 1, 12'h078, 32'h82);
    wb(1, 1, 12'h06C, 32'hEC);
    wb(0, 1, HOST_CTRL_ADDR, 32'h3B1);
    frame(TXV, TXV & 32'hFFFFFF);
    // Secondary data input from the high general-purpose pin.
    wb(1, 1, 12'h080, 1);
    frame(0, 32'hFFFFFF);
    // Every written sample has been loaded, so nothing is pending.
    wb(0, 0, HOST_STAT_ADDR, 0);
    chk(rd & 32'h1, 0);
    complete_run();
  end
endmodule // test_audio_port_clock_config
